/* File: design/apf_regs.svh */
// Timing counts and flag positions for the amplifier protection controller
`ifndef APF_REGS_SVH
`define APF_REGS_SVH

// ==========================================================
// Clock
`define APF_CLK_HZ 10000000
`define APF_CLK_KHZ 10000

// ==========================================================
// Output short test: typical time per microfarad of filter
`define APF_SHORT_MS_PER_UF 15
`define APF_SHORT_CAP_UF 1
// Two steps share the total time
`define APF_SHORT_STEPS 2
`define APF_SHORT_STEP_CYC ((`APF_SHORT_MS_PER_UF * `APF_CLK_KHZ * \
    `APF_SHORT_CAP_UF) / `APF_SHORT_STEPS)

// ==========================================================
// Overload shutdown after sustained current limiting
`define APF_OLP_US 1700
`define APF_OLP_CYC ((`APF_OLP_US * (`APF_CLK_HZ / 1000000)))

// Cycle current limit flips once every this many frames
`define APF_LIMIT_DIV 3

// Imbalance overload counter ceiling, in frames
`define APF_IMB_MAX 15

// Oscillator stall timeout in system clocks (slave mode)
`define APF_OSC_TIMEOUT_CYC 64

// Least wait after fault falls before the host restarts
`define APF_RESTART_MS 4

// ==========================================================
// Positions in the synchronised flag vector
`define APF_F_ANALOG_OK 0
`define APF_F_STAGE_OK 1
`define APF_F_TEMP_WARN 2
`define APF_F_TEMP_SHUT 3
`define APF_F_SHORT_GND 4
`define APF_F_SHORT_SUP 5
`define APF_F_CLIP 6
`define APF_F_ILIM0 7
`define APF_F_IMB0 9
`define APF_F_OSC 11
`define APF_F_CTL_RESET_N 12
`define APF_F_WIDTH 13

`endif

/* File: design/apf_pkg.sv */
// Types shared by the amplifier protection controller
package apf_pkg;

    // ==========================================================
    // Global sequencing states
    typedef enum logic [2:0] {
        APF_HELD,
        APF_POR,
        APF_TEST_GND,
        APF_TEST_SUP,
        APF_SHORT_HOLD,
        APF_RUN,
        APF_LATCHED
    } apf_state_t;

    // Which short test step was interrupted
    typedef enum logic {
        APF_STEP_GND,
        APF_STEP_SUP
    } apf_step_t;

endpackage

/* File: design/apf_chan_if.sv */
// Signals between the sequencer and one output channel monitor
`timescale 1ns/10ps
interface apf_chan_if;
    logic frame;
    logic ilimit;
    logic imbalance;
    logic clear;
    logic flip;
    logic trip;

    modport main (output frame, output ilimit, output imbalance,
        output clear, input flip, input trip);
    modport chan (input frame, input ilimit, input imbalance,
        input clear, output flip, output trip);
endinterface

/* File: design/apf_sync.sv */
// Two-stage synchroniser for a vector of asynchronous flags
`timescale 1ns/10ps
module apf_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // apf_sync

/* File: design/apf_chan.sv */
// Per-channel current limit, overload and imbalance monitor
`timescale 1ns/10ps
`include "apf_regs.svh"
module apf_chan
    import apf_pkg::*;
#(
    parameter int OLP_CYC = `APF_OLP_CYC,
    parameter int IMB_MAX = `APF_IMB_MAX
) (
    input wire logic clk_sys,
    input wire logic resetn,
    apf_chan_if.chan ch
);
    localparam int OW = $clog2(OLP_CYC + 1);
    localparam int IW = $clog2(IMB_MAX + 1);

    logic [OW-1:0] olp_q, olp_d;
    logic [IW-1:0] imb_q, imb_d;
    logic [1:0] div_q, div_d;
    logic flip_q, flip_d;
    logic trip_q, trip_d;

    // ==========================================================
    // Next values; trip wins over any limiting activity
    always_comb begin
        olp_d = olp_q;
        imb_d = imb_q;
        div_d = div_q;
        flip_d = flip_q;
        trip_d = trip_q;
        if (ch.clear) begin
            olp_d = '0;
            imb_d = '0;
            div_d = '0;
            flip_d = 1'b0;
            trip_d = 1'b0;
        end else begin
            // Limiting flips the bridge every third frame, silently
            if (ch.ilimit && !trip_q) begin
                if (ch.frame) begin
                    if (div_q == 2'(`APF_LIMIT_DIV - 1)) begin
                        div_d = '0;
                        flip_d = !flip_q;
                    end else begin
                        div_d = div_q + 2'd1;
                    end
                end
                if (olp_q != OW'(OLP_CYC)) begin
                    olp_d = olp_q + OW'(1);
                end else begin
                    trip_d = 1'b1;
                end
            end else begin
                // Self clearing once the limit condition drops
                olp_d = '0;
                div_d = '0;
                flip_d = 1'b0;
            end
            // Imbalance walks the counter to its ceiling, then trips
            if (ch.imbalance && ch.frame) begin
                if (imb_q != IW'(IMB_MAX)) begin
                    imb_d = imb_q + IW'(1);
                end else begin
                    trip_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            olp_q <= '0;
            imb_q <= '0;
            div_q <= '0;
            flip_q <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            olp_q <= olp_d;
            imb_q <= imb_d;
            div_q <= div_d;
            flip_q <= flip_d;
            trip_q <= trip_d;
        end
    end

    assign ch.flip = flip_q;
    assign ch.trip = trip_q;
endmodule // apf_chan

/* File: design/apf_protect.sv */
// Fault sequencing and reporting for a two-channel switching output stage
`timescale 1ns/10ps
`include "apf_regs.svh"

module apf_protect
    import apf_pkg::*;
#(
    parameter int SHORT_STEP_CYC = `APF_SHORT_STEP_CYC,
    parameter int OLP_CYC = `APF_OLP_CYC,
    parameter int IMB_MAX = `APF_IMB_MAX,
    parameter int OSC_TIMEOUT_CYC = `APF_OSC_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ctl_reset_n,
    input wire logic analog_supply_ok,
    input wire logic stage_supply_ok,
    input wire logic thermal_warning,
    input wire logic thermal_shutdown,
    input wire logic short_gnd_flag,
    input wire logic short_supply_flag,
    input wire logic clip_flag,
    input wire logic [1:0] cycle_current_limit,
    input wire logic [1:0] imbalance_flag,
    input wire logic ext_oscillator_pin,
    input wire logic slave_mode,
    input wire logic paralleled_bridge_config,
    input wire logic pwm_frame,
    output logic fault_n,
    output logic thermal_clip_warning_n,
    output logic [3:0] bridge_hiz,
    output logic [1:0] chan_flip,
    output logic [1:0] overload_shutdown,
    output logic output_short_test,
    output logic undervoltage_guard,
    output logic osc_stalled
);
    // ==========================================================
    // Parameter checks
    localparam int SW = $clog2(SHORT_STEP_CYC + 1);
    localparam int OSW = $clog2(OSC_TIMEOUT_CYC + 1);

    generate
        if (SHORT_STEP_CYC < 1) begin : g_bad_step
            $error("SHORT_STEP_CYC must be at least one");
        end
        if (OLP_CYC < 2) begin : g_bad_olp
            $error("OLP_CYC must be at least two");
        end
        if (IMB_MAX < 1) begin : g_bad_imb
            $error("IMB_MAX must be at least one");
        end
        if (OSC_TIMEOUT_CYC < 4) begin : g_bad_osc
            $error("OSC_TIMEOUT_CYC must be at least four");
        end
    endgenerate

    // ==========================================================
    // Synchronisers for every pin-side flag
    logic [`APF_F_WIDTH-1:0] raw_flags;
    logic [`APF_F_WIDTH-1:0] flags;

    assign raw_flags = {ctl_reset_n, ext_oscillator_pin, imbalance_flag,
        cycle_current_limit, clip_flag, short_supply_flag, short_gnd_flag,
        thermal_shutdown, thermal_warning, stage_supply_ok,
        analog_supply_ok};

    // Comparator flags are asynchronous to the sequencer
    apf_sync #(
        .W(`APF_F_WIDTH)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(raw_flags),
        .sync_out(flags)
    );

    logic s_analog_ok;
    logic s_stage_ok;
    logic s_temp_warn;
    logic s_temp_shut;
    logic s_short_gnd;
    logic s_short_sup;
    logic s_clip;
    logic s_osc;
    logic s_rst_n;

    assign s_analog_ok = flags[`APF_F_ANALOG_OK];
    assign s_stage_ok = flags[`APF_F_STAGE_OK];
    assign s_temp_warn = flags[`APF_F_TEMP_WARN];
    assign s_temp_shut = flags[`APF_F_TEMP_SHUT];
    assign s_short_gnd = flags[`APF_F_SHORT_GND];
    assign s_short_sup = flags[`APF_F_SHORT_SUP];
    assign s_clip = flags[`APF_F_CLIP];
    assign s_osc = flags[`APF_F_OSC];
    assign s_rst_n = flags[`APF_F_CTL_RESET_N];

    // ==========================================================
    // Oscillator activity watchdog (slave clock mode)
    logic osc_prev_q, osc_prev_d;
    logic [OSW-1:0] osc_cnt_q, osc_cnt_d;
    logic osc_lost;

    // Any edge of the synchronised oscillator restarts the count
    always_comb begin
        osc_prev_d = s_osc;
        osc_cnt_d = osc_cnt_q;
        if (s_osc != osc_prev_q) begin
            osc_cnt_d = '0;
        end else if (osc_cnt_q != OSW'(OSC_TIMEOUT_CYC)) begin
            osc_cnt_d = osc_cnt_q + OSW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            osc_prev_q <= 1'b0;
            osc_cnt_q <= '0;
        end else begin
            osc_prev_q <= osc_prev_d;
            osc_cnt_q <= osc_cnt_d;
        end
    end

    // Master mode makes its own clock, so a quiet pin means nothing
    assign osc_lost = slave_mode &&
        (osc_cnt_q == OSW'(OSC_TIMEOUT_CYC));

    // ==========================================================
    // Channel monitors
    apf_chan_if ch_if [2] ();
    logic [1:0] trip;
    logic [1:0] flip;
    logic clear_chan;
    apf_state_t state_q, state_d;
    apf_step_t step_q, step_d;
    logic [SW-1:0] timer_q, timer_d;

    // Latched channel faults are dropped only while reset is held
    assign clear_chan = (state_q == APF_HELD);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            assign ch_if[gi].frame = pwm_frame;
            assign ch_if[gi].ilimit = flags[`APF_F_ILIM0 + gi];
            // Imbalance is watched whatever the bridge configuration
            assign ch_if[gi].imbalance = flags[`APF_F_IMB0 + gi];
            assign ch_if[gi].clear = clear_chan;
            assign trip[gi] = ch_if[gi].trip;
            assign flip[gi] = ch_if[gi].flip;

            apf_chan #(
                .OLP_CYC(OLP_CYC),
                .IMB_MAX(IMB_MAX)
            ) u_chan (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .ch(ch_if[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Startup and global fault sequencer
    logic supply_bad;

    assign supply_bad = !s_analog_ok || !s_stage_ok;

    // Timer length per step tracks the filter capacitance parameter
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        timer_d = timer_q;
        if (!s_rst_n) begin
            // Reset low aborts everything and rearms the short test
            state_d = APF_HELD;
            timer_d = '0;
            step_d = APF_STEP_GND;
        end else if (s_temp_shut && state_q != APF_HELD) begin
            state_d = APF_LATCHED;
        end else begin
            unique case (state_q)
                APF_HELD: begin
                    // Reset has gone high: start again from power-on
                    state_d = APF_POR;
                end
                APF_POR: begin
                    if (!supply_bad) begin
                        state_d = APF_TEST_GND;
                        timer_d = '0;
                    end
                end
                APF_TEST_GND: begin
                    if (s_short_gnd) begin
                        state_d = APF_SHORT_HOLD;
                        step_d = APF_STEP_GND;
                    end else if (timer_q == SW'(SHORT_STEP_CYC - 1)) begin
                        state_d = APF_TEST_SUP;
                        timer_d = '0;
                    end else begin
                        timer_d = timer_q + SW'(1);
                    end
                end
                APF_TEST_SUP: begin
                    if (s_short_sup) begin
                        state_d = APF_SHORT_HOLD;
                        step_d = APF_STEP_SUP;
                    end else if (timer_q == SW'(SHORT_STEP_CYC - 1)) begin
                        state_d = APF_RUN;
                        timer_d = '0;
                    end else begin
                        timer_d = timer_q + SW'(1);
                    end
                end
                APF_SHORT_HOLD: begin
                    // Resume the step that found the short, from scratch
                    if (!s_short_gnd && !s_short_sup) begin
                        timer_d = '0;
                        state_d = (step_q == APF_STEP_GND) ?
                            APF_TEST_GND : APF_TEST_SUP;
                    end
                end
                APF_RUN: begin
                    state_d = APF_RUN;
                end
                APF_LATCHED: begin
                    // Only the reset input leaves this state
                    state_d = APF_LATCHED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= APF_HELD;
            step_q <= APF_STEP_GND;
            timer_q <= '0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            timer_q <= timer_d;
        end
    end

    // ==========================================================
    // Output decisions, registered so pins never glitch
    logic fault_n_q, fault_n_d;
    logic warn_n_q, warn_n_d;
    logic [3:0] hiz_q, hiz_d;
    logic [1:0] flip_q, flip_d;
    logic [1:0] olp_q, olp_d;
    logic test_q, test_d;
    logic uv_q, uv_d;
    logic stall_q, stall_d;
    logic global_off;
    logic startup;
    logic [1:0] chan_off;

    assign startup = (state_q == APF_POR) || (state_q == APF_TEST_GND) ||
        (state_q == APF_TEST_SUP) || (state_q == APF_SHORT_HOLD);

    // Undervoltage is checked live in every state, not only in run
    assign global_off = (state_q != APF_RUN) || supply_bad ||
        osc_lost;

    // A paralleled bridge is one channel, so one trip stops both
    assign chan_off[0] = trip[0] ||
        (paralleled_bridge_config && trip[1]);
    assign chan_off[1] = trip[1] ||
        (paralleled_bridge_config && trip[0]);

    always_comb begin
        hiz_d = {{2{global_off || chan_off[1]}},
            {2{global_off || chan_off[0]}}};
        // Flip only matters on a live bridge
        flip_d = flip & ~chan_off;
        olp_d = trip;
        test_d = (state_q == APF_TEST_GND) || (state_q == APF_TEST_SUP) ||
            (state_q == APF_SHORT_HOLD);
        uv_d = supply_bad;
        stall_d = osc_lost;
        // Warning stays independent of switching state
        warn_n_d = !(s_temp_warn || s_clip);
        if (!s_rst_n || state_q == APF_HELD) begin
            fault_n_d = 1'b1;
        end else begin
            // Stall and current limiting are deliberately not reported
            fault_n_d = !(startup || (state_q == APF_LATCHED) ||
                supply_bad || (|trip));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fault_n_q <= 1'b1;
            warn_n_q <= 1'b1;
            hiz_q <= 4'hf;
            flip_q <= 2'h0;
            olp_q <= 2'h0;
            test_q <= 1'b0;
            uv_q <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            fault_n_q <= fault_n_d;
            warn_n_q <= warn_n_d;
            hiz_q <= hiz_d;
            flip_q <= flip_d;
            olp_q <= olp_d;
            test_q <= test_d;
            uv_q <= uv_d;
            stall_q <= stall_d;
        end
    end

    assign fault_n = fault_n_q;
    assign thermal_clip_warning_n = warn_n_q;
    assign bridge_hiz = hiz_q;
    assign chan_flip = flip_q;
    assign overload_shutdown = olp_q;
    assign output_short_test = test_q;
    assign undervoltage_guard = uv_q;
    assign osc_stalled = stall_q;
endmodule // apf_protect

/* File: tb/apf_protect_checker.sv */
// Concurrent checks on the protection controller top ports
`timescale 1ns/10ps
module apf_protect_checker (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ctl_reset_n,
    input wire logic analog_supply_ok,
    input wire logic stage_supply_ok,
    input wire logic thermal_warning,
    input wire logic thermal_shutdown,
    input wire logic clip_flag,
    input wire logic fault_n,
    input wire logic thermal_clip_warning_n,
    input wire logic [3:0] bridge_hiz,
    input wire logic [1:0] overload_shutdown,
    input wire logic output_short_test,
    input wire logic osc_stalled
);
    // ==========================================================
    // Properties, all in the system clock domain
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Windows of 4 to 6 cycles cover the two-flop sync plus decide and reg
    rst_forces_high_a: assert property (
        (!ctl_reset_n) [*4] |=> fault_n)
        else $error("fault output low while reset pin held");
    uv_stage_off_a: assert property ((resetn && ctl_reset_n &&
        !(stage_supply_ok && analog_supply_ok)) [*6]
        |-> (!fault_n && bridge_hiz == 4'hf))
        else $error("supply low but stage not off");
    warn_set_a: assert property (
        (resetn && ctl_reset_n && thermal_warning) [*5]
        |-> !thermal_clip_warning_n)
        else $error("thermal warning not shown");
    warn_clear_a: assert property (
        (resetn && !thermal_warning && !clip_flag) [*5]
        |-> thermal_clip_warning_n)
        else $error("warning output stuck low");
    ote_latch_a: assert property (
        (resetn && ctl_reset_n && thermal_shutdown) [*5]
        ##1 (resetn && ctl_reset_n) [*8]
        |-> (!fault_n && bridge_hiz == 4'hf))
        else $error("thermal shutdown not latched");
    olp_off_a: assert property ($rose(overload_shutdown[0])
        |-> ##[0:2] (bridge_hiz[1:0] == 2'b11 && !fault_n))
        else $error("channel trip without stage off and fault");
    olp_hold_a: assert property (overload_shutdown[0] && ctl_reset_n &&
        $past(ctl_reset_n) && $past(ctl_reset_n, 2)
        |=> overload_shutdown[0])
        else $error("channel trip cleared without reset");
    short_fault_a: assert property ($rose(output_short_test)
        |-> (!fault_n && bridge_hiz == 4'hf) [*4])
        else $error("short test running with fault released");
    osc_quiet_a: assert property ($rose(osc_stalled) && fault_n
        |-> ##[0:1] (bridge_hiz == 4'hf && fault_n))
        else $error("oscillator stall not handled silently");

    // Main scenarios reached
    cover property ($rose(overload_shutdown[0]));
    cover property ($fell(output_short_test));
    cover property ($rose(osc_stalled));
endmodule // apf_protect_checker

bind apf_protect apf_protect_checker chk (.*);

/* File: tb/apf_host.sv */
// Host controller model driving the reset pin
`timescale 1ns/10ps
module apf_host #(
    parameter int RESTART_CYC = 40000
) (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic fault_n,
    input wire logic thermal_clip_warning_n,
    output logic ctl_reset_n = 1'b0
);
    // ==========================================================
    // Starts saturated so the first release needs no wait
    int quiet_q = RESTART_CYC;
    logic fault_q = 1'b1;

    // Release only when cool and long enough after the last fault fall
    always @(negedge clk_sys) begin
        fault_q <= fault_n;
        if (fault_q && !fault_n)
            quiet_q <= 0;
        else if (quiet_q < RESTART_CYC)
            quiet_q <= quiet_q + 1;
        if (!go)
            ctl_reset_n <= 1'b0;
        else if (quiet_q >= RESTART_CYC && thermal_clip_warning_n === 1'b1)
            ctl_reset_n <= 1'b1;
    end
endmodule // apf_host

/* File: tb/apf_protect_test.sv */
// Self-checking bench for the protection controller
`timescale 1ns/10ps
module apf_protect_test;
    logic clk_sys, resetn, go, analog_supply_ok, stage_supply_ok;
    logic thermal_warning, thermal_shutdown, short_gnd_flag, osc_run;
    logic short_supply_flag, clip_flag, slave_mode;
    logic paralleled_bridge_config, ctl_reset_n, fault_n;
    logic pwm_frame = 1'b0;
    logic ext_oscillator_pin = 1'b0;
    logic [1:0] fcnt = 2'h0;
    logic thermal_clip_warning_n, output_short_test, undervoltage_guard;
    logic osc_stalled;
    logic [1:0] cycle_current_limit, imbalance_flag, chan_flip;
    logic [1:0] overload_shutdown;
    logic [3:0] bridge_hiz;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    int k;

    // Short counts keep the run brief
    apf_protect #(.SHORT_STEP_CYC(8), .OLP_CYC(20), .IMB_MAX(15),
        .OSC_TIMEOUT_CYC(16)) DUT (.*);
    apf_host #(.RESTART_CYC(10)) host (.*);

    // ==========================================================
    // Clock, frame pulse every 4 cycles, oscillator
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        fcnt <= fcnt + 2'd1;
        pwm_frame <= (fcnt == 2'd3);
        if (osc_run)
            ext_oscillator_pin <= ~ext_oscillator_pin;
    end
    // Hang guard, well above the whole sequence
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [3:0] seen,
        input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic run_ok;
        chk("fault", 4'(fault_n), 4'h1);
        chk("hiz", bridge_hiz, 4'h0);
        chk("testing", 4'(output_short_test), 4'h0);
    endtask
    task automatic off_ok;
        chk("fault", 4'(fault_n), 4'h0);
        chk("hiz", bridge_hiz, 4'hf);
    endtask
    // Reset pin cycle through the host, short test seen mid-way
    task automatic restart;
        go = 1'b0;
        tick(6);
        chk("fault held", 4'(fault_n), 4'h1);
        go = 1'b1;
        i = 0;
        while (ctl_reset_n !== 1'b1 && i < 200) begin
            tick(1);
            i++;
        end
        tick(8);
        chk("short test", 4'(output_short_test), 4'h1);
        off_ok();
        tick(32);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {resetn, go, thermal_warning, thermal_shutdown, clip_flag} = '0;
        {short_gnd_flag, short_supply_flag, slave_mode} = '0;
        paralleled_bridge_config = 1'b0;
        {cycle_current_limit, imbalance_flag} = '0;
        {analog_supply_ok, stage_supply_ok, osc_run} = 3'b111;
        tick(2);
        resetn = 1'b1;
        restart();
        run_ok();
        // Short to ground, then to supply, holds the stage off
        for (k = 0; k < 2; k++) begin
            short_gnd_flag = (k == 0);
            short_supply_flag = (k == 1);
            restart();
            chk("short hold", 4'(output_short_test), 4'h1);
            off_ok();
            {short_gnd_flag, short_supply_flag} = 2'b00;
            tick(40);
            run_ok();
        end
        // Warning pin shows heat or clipping, without stopping the stage
        for (k = 0; k < 2; k++) begin
            thermal_warning = (k == 0);
            clip_flag = (k == 1);
            tick(6);
            chk("warn", 4'(thermal_clip_warning_n), 4'h0);
            run_ok();
            {thermal_warning, clip_flag} = 2'b00;
            tick(6);
            chk("warn", 4'(thermal_clip_warning_n), 4'h1);
        end
        // Either supply low turns the stage off, then recovers alone
        for (k = 0; k < 2; k++) begin
            analog_supply_ok = (k != 0);
            stage_supply_ok = (k == 0);
            tick(6);
            off_ok();
            chk("uv", 4'(undervoltage_guard), 4'h1);
            {analog_supply_ok, stage_supply_ok} = 2'b11;
            tick(40);
            run_ok();
            chk("uv", 4'(undervoltage_guard), 4'h0);
        end
        // Sustained limit on one channel trips only that channel
        cycle_current_limit = 2'b01;
        tick(16);
        chk("flip", 4'(chan_flip), 4'h1);
        tick(14);
        cycle_current_limit = 2'b00;
        tick(10);
        chk("trip", 4'(overload_shutdown), 4'h1);
        chk("flip", 4'(chan_flip), 4'h0);
        chk("hiz", bridge_hiz, 4'h3);
        chk("fault", 4'(fault_n), 4'h0);
        restart();
        chk("trip", 4'(overload_shutdown), 4'h0);
        run_ok();
        // Imbalance in the paralleled build turns both channels off
        paralleled_bridge_config = 1'b1;
        imbalance_flag = 2'b10;
        tick(72);
        off_ok();
        chk("trip", 4'(overload_shutdown), 4'h2);
        imbalance_flag = 2'b00;
        restart();
        run_ok();
        paralleled_bridge_config = 1'b0;
        thermal_shutdown = 1'b1;
        tick(6);
        thermal_shutdown = 1'b0;
        tick(20);
        off_ok();
        restart();
        run_ok();
        // Oscillator stall in slave mode is silent and self clearing
        slave_mode = 1'b1;
        osc_run = 1'b0;
        tick(30);
        chk("stall", 4'(osc_stalled), 4'h1);
        chk("hiz", bridge_hiz, 4'hf);
        chk("fault", 4'(fault_n), 4'h1);
        osc_run = 1'b1;
        tick(40);
        chk("stall", 4'(osc_stalled), 4'h0);
        run_ok();
        wrap_up();
    end
endmodule // apf_protect_test
